// >>> hw/ciu_top.sv
// issue, branch prediction, translation buffer and interrupt control unit
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`default_nettype none
module ciu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic pair_valid,
  input wire logic [1:0] unit0,
  input wire logic [1:0] unit1,
  input wire logic [2:0] unit_ready,
  output logic issue0,
  output logic issue1,
  output logic pair_done,
  input wire logic br_valid,
  input wire logic [7:0] br_index,
  input wire logic br_disp_sign,
  input wire logic [1:0] br_hint,
  input wire logic [42:0] br_return_pc,
  input wire logic br_resolve,
  input wire logic [7:0] br_resolve_index,
  input wire logic br_taken,
  input wire logic icache_fill,
  input wire logic [7:0] icache_fill_index,
  output logic pred_taken,
  output logic [42:0] rs_target,
  output logic rs_target_valid,
  input wire logic [42:0] virtual_program_counter,
  input wire logic [1:0] cur_mode,
  input wire logic firmware_mode,
  output logic itb_hit,
  output logic [20:0] itb_pfn,
  output logic [3:0] itb_prot,
  output logic itb_asm,
  input wire logic [6:1] hw_irq_pin,
  input wire logic pipe_drained,
  input wire logic dfill_pending,
  input wire logic [42:0] restart_pc,
  output logic irq_take
);
  import ciu_pkg::*;

  // register bus slave
  logic [7:0] aw_q_r;
  logic [31:0] wd_q_r;
  logic [3:0] ws_q_r;
  logic rd_go, wr_go, wr_hit, rd_hit;
  logic [31:0] wmask, rd_val;
  assign rd_go = arvalid && arready;
  // reads go first so entry pointer side effects never collide
  assign wr_go = !awready && !wready && !bvalid && !rd_go;
  assign wmask = {{8{ws_q_r[3]}}, {8{ws_q_r[2]}}, {8{ws_q_r[1]}}, {8{ws_q_r[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_q_r <= 8'h00;
      wd_q_r <= 32'h0;
      ws_q_r <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_q_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd_q_r <= wdata;
        ws_q_r <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // software visible state
  logic [2:0] ctl_r;
  logic [29:0] tag_r;
  logic [31:0] temp_r;
  logic tsel_r;
  logic [15:0] sreq_r, sen_r;
  logic [3:0] treq_r, ten_r;
  logic [6:0] hen_r;
  logic [42:0] ra_r;
  logic [6:1] hw_s1_r, hw_s2_r;
  logic [31:0] entry_rd;

  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      OFF_CTL: rd_val = {29'h0, ctl_r};
      OFF_TAG: rd_val = {2'h0, tag_r};
      OFF_ENTRY: rd_val = 32'h0;
      OFF_TEMP: rd_val = temp_r;
      OFF_TSEL: rd_val = {31'h0, tsel_r};
      OFF_SPINV: rd_val = 32'h0;
      OFF_SREQ: rd_val = {16'h0, sreq_r};
      OFF_TREQ: rd_val = {28'h0, treq_r};
      OFF_SEN: rd_val = {16'h0, sen_r};
      OFF_HEN: rd_val = {25'h0, hen_r};
      OFF_HREQ: rd_val = {25'h0, hw_s2_r, 1'b0};
      OFF_RA_LO: rd_val = ra_r[31:0];
      OFF_RA_HI: rd_val = {21'h0, ra_r[42:32]};
      OFF_TEN: rd_val = {28'h0, ten_r};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    unique case (aw_q_r)
      OFF_CTL, OFF_TAG, OFF_ENTRY, OFF_TSEL, OFF_SPINV, OFF_SREQ, OFF_TREQ, OFF_SEN,
      OFF_HEN, OFF_RA_LO, OFF_RA_HI, OFF_TEN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  logic wr_entry, rd_entry, wr_spinv;
  assign wr_entry = wr_go && aw_q_r == OFF_ENTRY;
  assign rd_entry = rd_go && araddr == OFF_ENTRY;
  assign wr_spinv = wr_go && aw_q_r == OFF_SPINV;

  // pins come from outside the clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_s1_r <= 6'h0;
      hw_s2_r <= 6'h0;
    end else begin
      hw_s1_r <= hw_irq_pin;
      hw_s2_r <= hw_s1_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= CTL_RST;
      tag_r <= 30'h0;
      tsel_r <= 1'b0;
      sreq_r <= 16'h0;
      treq_r <= 4'h0;
      sen_r <= 16'h0;
      ten_r <= 4'h0;
      hen_r <= 7'h0;
    end else if (wr_go) begin
      unique case (aw_q_r)
        OFF_CTL: ctl_r <= 3'(merge({29'h0, ctl_r}, wd_q_r, wmask));
        OFF_TAG: tag_r <= 30'(merge({2'h0, tag_r}, wd_q_r, wmask));
        OFF_TSEL: tsel_r <= wd_q_r[0] & ws_q_r[0];
        OFF_SREQ: sreq_r <= 16'(merge({16'h0, sreq_r}, wd_q_r, wmask)) & SOFT_MASK;
        OFF_TREQ: treq_r <= 4'(merge({28'h0, treq_r}, wd_q_r, wmask));
        OFF_SEN: sen_r <= 16'(merge({16'h0, sen_r}, wd_q_r, wmask)) & SOFT_MASK;
        OFF_HEN: hen_r <= 7'(merge({25'h0, hen_r}, wd_q_r, wmask)) & HW_MASK;
        OFF_TEN: ten_r <= 4'(merge({28'h0, ten_r}, wd_q_r, wmask));
        default: ;
      endcase
    end
  end

  // interrupt decision
  logic [3:0] trap_ok;
  logic irq_pend;
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      // a mode's trap waits while running more privileged than that mode
      trap_ok[m] = treq_r[m] && ten_r[m] && (2'(m) <= cur_mode);
    end
  end
  assign irq_pend = |(hw_s2_r & hen_r[6:1]) || |(sreq_r & sen_r) ||
                    (|trap_ok && sen_r[SEN_TRAP_GATE]);

  logic take;
  assign take = irq_pend && !firmware_mode && pipe_drained && !dfill_pending;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_take <= 1'b0;
      ra_r <= 43'h0;
    end else begin
      irq_take <= take;
      if (take) begin
        ra_r <= restart_pc;
      end else if (wr_go && aw_q_r == OFF_RA_LO) begin
        ra_r[31:0] <= merge(ra_r[31:0], wd_q_r, wmask);
      end else if (wr_go && aw_q_r == OFF_RA_HI) begin
        ra_r[42:32] <= 11'(merge({21'h0, ra_r[42:32]}, wd_q_r, wmask));
      end
    end
  end

  // issue: a pending interrupt stops issue so the pipe can drain
  ciu_iss_t iss_r;
  logic ok0, ok1;
  assign ok0 = unit_ready[unit0];
  assign ok1 = unit_ready[unit1] && (unit1 != unit0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iss_r <= ISS_PAIR;
      issue0 <= 1'b0;
      issue1 <= 1'b0;
      pair_done <= 1'b0;
    end else begin
      issue0 <= 1'b0;
      issue1 <= 1'b0;
      pair_done <= 1'b0;
      // same pair still stands while pair_done is up
      if (pair_valid && !irq_pend && !pair_done) begin
        unique case (iss_r)
          ISS_PAIR: begin
            if (ok0 && ok1) begin
              issue0 <= 1'b1;
              issue1 <= 1'b1;
              pair_done <= 1'b1;
            end else if (ok0) begin
              issue0 <= 1'b1;
              iss_r <= ISS_SECOND;
            end
          end
          ISS_SECOND: begin
            // no pulling forward: the second goes alone
            if (unit_ready[unit1]) begin
              issue1 <= 1'b1;
              pair_done <= 1'b1;
              iss_r <= ISS_PAIR;
            end
          end
        endcase
      end
    end
  end

  // branch history and return stack
  logic hist_r [HIST_N];
  logic seen_r [HIST_N];
  logic [42:0] rs_r [RS_N];
  logic [2:0] rs_cnt_r;
  logic pred_on;
  assign pred_on = !ctl_r[CTL_PRED_DIS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < HIST_N; i++) begin
        seen_r[i] <= 1'b0;
        hist_r[i] <= 1'b0;
      end
    end else begin
      if (icache_fill) begin
        seen_r[icache_fill_index] <= 1'b0;
      end
      // a resolve in the same cycle as a refill wins
      if (br_resolve) begin
        hist_r[br_resolve_index] <= br_taken;
        seen_r[br_resolve_index] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pred_taken <= 1'b0;
    end else if (br_valid) begin
      if (!pred_on) begin
        pred_taken <= 1'b0;
      end else if (ctl_r[CTL_HIST_EN] && seen_r[br_index]) begin
        pred_taken <= hist_r[br_index];
      end else begin
        pred_taken <= br_disp_sign;
      end
    end
  end

  logic rs_pop;
  assign rs_pop = br_valid && pred_on && (br_hint == HINT_POP || br_hint == HINT_COROUT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_cnt_r <= 3'h0;
      rs_target <= 43'h0;
      rs_target_valid <= 1'b0;
      for (int i = 0; i < RS_N; i++) begin
        rs_r[i] <= 43'h0;
      end
    end else begin
      rs_target_valid <= rs_pop && rs_cnt_r != 3'h0;
      if (rs_pop) begin
        rs_target <= rs_r[0];
      end
      if (br_valid && pred_on && br_hint == HINT_PUSH) begin
        // oldest entry falls off the bottom when full
        for (int i = 1; i < RS_N; i++) begin
          rs_r[i] <= rs_r[i-1];
        end
        rs_r[0] <= br_return_pc;
        rs_cnt_r <= (rs_cnt_r == 3'(RS_N)) ? rs_cnt_r : rs_cnt_r + 3'h1;
      end else if (br_valid && pred_on && br_hint == HINT_COROUT) begin
        rs_r[0] <= br_return_pc;
      end else if (rs_pop) begin
        for (int i = 0; i < RS_N - 1; i++) begin
          rs_r[i] <= rs_r[i+1];
        end
        rs_cnt_r <= (rs_cnt_r == 3'h0) ? 3'h0 : rs_cnt_r - 3'h1;
      end
    end
  end

  // instruction translation buffers
  logic [29:0] s_tag_r [SMALL_N];
  logic [20:0] s_pfn_r [SMALL_N];
  logic [3:0] s_prot_r [SMALL_N];
  logic [SMALL_N-1:0] s_val_r, s_asm_r;
  logic [20:0] l_tag_r [LARGE_N];
  logic [11:0] l_pfn_r [LARGE_N];
  logic [3:0] l_prot_r [LARGE_N];
  logic [LARGE_N-1:0] l_val_r, l_asm_r;
  logic [2:0] sptr_r;
  logic [1:0] lptr_r;
  logic hit, hit_asm, s_hit, l_hit;
  logic [20:0] hit_pfn;
  logic [3:0] hit_prot;
  logic [2:0] s_idx;
  logic [1:0] l_idx;

  always_comb begin
    hit = 1'b0;
    hit_asm = 1'b0;
    hit_pfn = 21'h0;
    hit_prot = 4'h0;
    s_hit = 1'b0;
    l_hit = 1'b0;
    s_idx = 3'h0;
    l_idx = 2'h0;
    for (int i = 0; i < SMALL_N; i++) begin
      if (s_val_r[i] && s_tag_r[i] == virtual_program_counter[42:13]) begin
        s_hit = 1'b1;
        s_idx = 3'(i);
        hit_pfn = s_pfn_r[i];
        hit_prot = s_prot_r[i];
        hit_asm = s_asm_r[i];
      end
    end
    for (int i = 0; i < LARGE_N; i++) begin
      if (l_val_r[i] && l_tag_r[i] == virtual_program_counter[42:22]) begin
        l_hit = 1'b1;
        l_idx = 2'(i);
        hit_pfn = {l_pfn_r[i], virtual_program_counter[21:13]};
        hit_prot = l_prot_r[i];
        hit_asm = l_asm_r[i];
      end
    end
    hit = s_hit || l_hit;
    if (ctl_r[CTL_MAP] && virtual_program_counter[42:41] == 2'b10 && cur_mode == MODE_KERNEL) begin
      hit = 1'b1;
      hit_pfn = virtual_program_counter[33:13];
      hit_prot = 4'h0;
      hit_asm = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      itb_hit <= 1'b0;
      itb_pfn <= 21'h0;
      itb_prot <= 4'h0;
      itb_asm <= 1'b0;
    end else begin
      itb_hit <= hit && !firmware_mode;
      itb_pfn <= hit_pfn;
      itb_prot <= hit_prot;
      itb_asm <= hit_asm;
    end
  end

  assign entry_rd = tsel_r ?
      {6'h0, l_prot_r[lptr_r], l_asm_r[lptr_r], l_pfn_r[lptr_r], 9'h0} :
      {6'h0, s_prot_r[sptr_r], s_asm_r[sptr_r], s_pfn_r[sptr_r]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_val_r <= '0;
      l_val_r <= '0;
      s_asm_r <= '0;
      l_asm_r <= '0;
      sptr_r <= 3'h0;
      lptr_r <= 2'h0;
      temp_r <= 32'h0;
      for (int i = 0; i < SMALL_N; i++) begin
        s_tag_r[i] <= 30'h0;
        s_pfn_r[i] <= 21'h0;
        s_prot_r[i] <= 4'h0;
      end
      for (int i = 0; i < LARGE_N; i++) begin
        l_tag_r[i] <= 21'h0;
        l_pfn_r[i] <= 12'h0;
        l_prot_r[i] <= 4'h0;
      end
    end else begin
      if (rd_entry) begin
        temp_r <= entry_rd;
      end
      if (wr_entry && !tsel_r) begin
        s_tag_r[sptr_r] <= tag_r;
        s_pfn_r[sptr_r] <= wd_q_r[20:0];
        s_asm_r[sptr_r] <= wd_q_r[ENT_ASM];
        s_prot_r[sptr_r] <= wd_q_r[ENT_PROT_LO+:4];
        s_val_r[sptr_r] <= 1'b1;
      end
      if (wr_entry && tsel_r) begin
        l_tag_r[lptr_r] <= tag_r[29:9];
        l_pfn_r[lptr_r] <= wd_q_r[20:9];
        l_asm_r[lptr_r] <= wd_q_r[ENT_ASM];
        l_prot_r[lptr_r] <= wd_q_r[ENT_PROT_LO+:4];
        l_val_r[lptr_r] <= 1'b1;
      end
      if (wr_spinv) begin
        s_val_r <= s_val_r & s_asm_r;
        l_val_r <= l_val_r & l_asm_r;
      end
      // register access steps the selected pointer; else skip the entry just used
      if ((wr_entry || rd_entry) && !tsel_r) begin
        sptr_r <= sptr_r + 3'h1;
      end else if (itb_hit && s_hit && s_idx == sptr_r && !firmware_mode) begin
        sptr_r <= sptr_r + 3'h1;
      end
      if ((wr_entry || rd_entry) && tsel_r) begin
        lptr_r <= lptr_r + 2'h1;
      end else if (itb_hit && l_hit && l_idx == lptr_r && !firmware_mode) begin
        lptr_r <= lptr_r + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/ciu_pkg.sv
// constants and register map of the issue and interrupt unit
`default_nettype none
package ciu_pkg;
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_TAG = 8'h04;
  localparam logic [7:0] OFF_ENTRY = 8'h08;
  localparam logic [7:0] OFF_TEMP = 8'h0c;
  localparam logic [7:0] OFF_TSEL = 8'h10;
  localparam logic [7:0] OFF_SPINV = 8'h14;
  localparam logic [7:0] OFF_SREQ = 8'h18;
  localparam logic [7:0] OFF_TREQ = 8'h1c;
  localparam logic [7:0] OFF_SEN = 8'h20;
  localparam logic [7:0] OFF_HEN = 8'h24;
  localparam logic [7:0] OFF_HREQ = 8'h28;
  localparam logic [7:0] OFF_RA_LO = 8'h2c;
  localparam logic [7:0] OFF_RA_HI = 8'h30;
  localparam logic [7:0] OFF_TEN = 8'h34;
  // control register fields
  localparam int CTL_HIST_EN = 0;
  localparam int CTL_PRED_DIS = 1;
  localparam int CTL_MAP = 2;
  localparam logic [2:0] CTL_RST = 3'h1;
  localparam logic [15:0] SOFT_MASK = 16'hfffe;
  localparam logic [6:0] HW_MASK = 7'h7e;
  localparam int SEN_TRAP_GATE = 2;
  // entry word layout
  localparam int ENT_ASM = 21;
  localparam int ENT_PROT_LO = 22;
  localparam int SMALL_N = 8;
  localparam int LARGE_N = 4;
  localparam int RS_N = 4;
  localparam int HIST_N = 256;
  // execution units
  localparam logic [1:0] UNIT_INT = 2'h0;
  localparam logic [1:0] UNIT_LDST = 2'h1;
  localparam logic [1:0] UNIT_FP = 2'h2;
  // return stack hints
  localparam logic [1:0] HINT_PUSH = 2'h1;
  localparam logic [1:0] HINT_POP = 2'h2;
  localparam logic [1:0] HINT_COROUT = 2'h3;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ISS_PAIR = 2'b01, ISS_SECOND = 2'b10} ciu_iss_t;
endpackage
`default_nettype wire

// >>> tb/ciu_monitor.sv
// concurrent checks on the issue, branch, lookup and interrupt ports
`default_nettype none
module ciu_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [1:0] unit0,
  input wire logic [1:0] unit1,
  input wire logic [2:0] unit_ready,
  input wire logic issue0,
  input wire logic issue1,
  input wire logic br_valid,
  input wire logic [1:0] br_hint,
  input wire logic rs_target_valid,
  input wire logic pred_taken,
  input wire logic firmware_mode,
  input wire logic pipe_drained,
  input wire logic dfill_pending,
  input wire logic irq_take,
  input wire logic itb_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  // slot0 went alone, slot1 still owed
  logic first_only_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || issue1) first_only_r <= 1'b0;
    else if (issue0) first_only_r <= 1'b1;
  end
  dual_units_a: assert property (issue0 && issue1 |-> $past(unit0) != $past(unit1))
    else $error("two instructions sent to one unit");
  slot0_ready_a: assert property (issue0 |-> $past(unit_ready[unit0]))
    else $error("slot0 issued to a busy unit");
  slot1_ready_a: assert property (issue1 |-> $past(unit_ready[unit1]))
    else $error("slot1 issued to a busy unit");
  slot_order_a: assert property (issue1 && !issue0 |-> first_only_r)
    else $error("slot1 issued before slot0");
  irq_gate_a: assert property (irq_take |->
      !$past(firmware_mode) && $past(pipe_drained) && !$past(dfill_pending))
    else $error("interrupt taken while not allowed");
  rs_pop_a: assert property (rs_target_valid |-> $past(br_valid) && $past(br_hint[1]))
    else $error("return address without a pop hint");
  pred_hold_a: assert property ($changed(pred_taken) |-> $past(br_valid))
    else $error("prediction changed without a branch");
  lookup_fw_a: assert property (itb_hit |-> !$past(firmware_mode))
    else $error("lookup hit in firmware mode");
  read_next_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not on next cycle");
endmodule
bind ciu_top ciu_monitor i_mon (.aclk, .aresetn, .arvalid, .arready, .rvalid, .unit0, .unit1,
  .unit_ready, .issue0, .issue1, .br_valid, .br_hint, .rs_target_valid, .pred_taken,
  .firmware_mode, .pipe_drained, .dfill_pending, .irq_take, .itb_hit);
`default_nettype wire

// >>> tb/ciu_units_model.sv
// execution units seen from the issue side: readiness and accepted count
`default_nettype none
module ciu_units_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] stall,
  input wire logic issue0,
  input wire logic issue1,
  output logic [2:0] unit_ready,
  output logic [7:0] accepted
);
  timeunit 1ns;
  timeprecision 100ps;
  // a stalled unit answers slowly by staying busy
  assign unit_ready = ~stall;
  always_ff @(posedge aclk) begin
    if (!aresetn) accepted <= 8'h00;
    else accepted <= accepted + 8'(issue0) + 8'(issue1);
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the issue and interrupt unit
`default_nettype none
module tb_top;
  import ciu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1, pair_valid = 1'b0, br_valid = 1'b0;
  logic br_disp_sign = 1'b0, br_resolve = 1'b0, br_taken = 1'b0, icache_fill = 1'b0;
  logic firmware_mode = 1'b0, pipe_drained = 1'b1, dfill_pending = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, br_index = 8'h00, br_resolve_index = 8'h00;
  logic [7:0] icache_fill_index = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] unit0 = 2'h0, unit1 = 2'h0, br_hint = 2'h0, cur_mode = 2'h0;
  logic [2:0] stall = 3'h0;
  logic [42:0] br_return_pc = '0, virtual_program_counter = '0, restart_pc = '0;
  logic [6:1] hw_irq_pin = 6'h0;
  logic awready, wready, bvalid, arready, rvalid, issue0, issue1, pair_done, pred_taken;
  logic rs_target_valid, itb_hit, itb_asm, irq_take;
  logic [7:0] accepted;
  logic [31:0] rdata, q;
  logic [3:0] itb_prot;
  logic [1:0] bresp, rresp, r;
  logic [2:0] unit_ready;
  logic [42:0] rs_target;
  logic [20:0] itb_pfn;
  int fail_count = 0, compares = 0;
  ciu_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pair_valid, .unit0, .unit1, .unit_ready, .issue0, .issue1, .pair_done,
    .br_valid, .br_index, .br_disp_sign, .br_hint, .br_return_pc, .br_resolve,
    .br_resolve_index, .br_taken, .icache_fill, .icache_fill_index, .pred_taken, .rs_target,
    .rs_target_valid, .virtual_program_counter, .cur_mode, .firmware_mode, .itb_hit, .itb_pfn, .itb_prot,
    .itb_asm, .hw_irq_pin, .pipe_drained, .dfill_pending, .restart_pc, .irq_take);
  ciu_units_model i_units (.aclk, .aresetn, .stall, .issue0, .issue1, .unit_ready, .accepted);
  always #50 aclk = ~aclk;
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [42:0] got, input logic [42:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one transfer at a time; bready and rready stay high; each channel released at its handshake
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    for (n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if ((bvalid && bready) || (rvalid && rready)) begin
        r = w ? bresp : rresp;
        q = rdata;
        done = 1'b1;
      end
    end
    if (!done) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi(1'b0, a, 32'h0);
    chk(nm, q, e);
    chk("read okay", r, RESP_OKAY);
  endtask
  task automatic t_regs();
    rd(OFF_CTL, {29'h0, CTL_RST}, "control");
    rd(OFF_HEN, 32'h0, "hw enable");
    axi(1'b1, OFF_HEN, 32'hffffffff);
    rd(OFF_HEN, {25'h0, HW_MASK}, "hw enable");
    axi(1'b1, OFF_SEN, 32'hffffffff);
    rd(OFF_SEN, {16'h0, SOFT_MASK}, "soft enable");
    axi(1'b1, OFF_TEN, 32'hffffffff);
    rd(OFF_TEN, 32'hf, "trap enable");
    axi(1'b0, 8'hfc, 32'h0);
    chk("unmapped read", {r, q}, {RESP_SLVERR, 32'h0});
    axi(1'b1, 8'hfc, 32'h0);
    chk("unmapped write", r, RESP_SLVERR);
    axi(1'b1, OFF_HEN, 32'h0);
    axi(1'b1, OFF_SEN, 32'h0);
    axi(1'b1, OFF_TEN, 32'h0);
    $display("register test done");
  endtask
  // holds the pair until done; stall lifted at loop step rel
  task automatic pair(input logic [1:0] a, b, input logic [2:0] st, input int rel,
      output int c0, c1);
    int n;
    pair_valid <= 1'b1;
    unit0 <= a;
    unit1 <= b;
    stall <= st;
    c0 = -1;
    c1 = -1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (n == rel) stall <= 3'h0;
      if (issue0 && c0 < 0) c0 = n;
      if (issue1 && c1 < 0) c1 = n;
      if (pair_done) break;
    end
    if (n == 20) begin
      fail_count++;
      summarize();
    end
    pair_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_issue();
    int c0, c1;
    pair(UNIT_INT, UNIT_FP, 3'h0, 99, c0, c1);
    chk("dual issue", c0 == c1 && c0 >= 0, 1'b1);
    pair(UNIT_LDST, UNIT_LDST, 3'h0, 99, c0, c1);
    chk("same unit", c1 > c0 && c0 >= 0, 1'b1);
    pair(UNIT_INT, UNIT_FP, 3'h1, 5, c0, c1);
    chk("first blocked", c0 > 5 && c0 == c1, 1'b1);
    pair(UNIT_INT, UNIT_FP, 3'h4, 5, c0, c1);
    chk("second blocked", c0 >= 0 && c0 < 5 && c1 > 5, 1'b1);
    chk("accepted", accepted, 8'h08);
    $display("issue test done");
  endtask
  task automatic br(input logic [7:0] i, input logic s, input logic [1:0] h, input int pc);
    br_valid <= 1'b1;
    br_index <= i;
    br_disp_sign <= s;
    br_hint <= h;
    br_return_pc <= 43'(pc);
    @(posedge aclk);
    br_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic t_branch();
    int i;
    br(8'h0a, 1'b1, 2'h0, 0);
    chk("sign negative", pred_taken, 1'b1);
    br(8'h0b, 1'b0, 2'h0, 0);
    chk("sign positive", pred_taken, 1'b0);
    br_resolve <= 1'b1;
    br_resolve_index <= 8'h0a;
    @(posedge aclk);
    br_resolve <= 1'b0;
    br(8'h0a, 1'b1, 2'h0, 0);
    chk("history", pred_taken, 1'b0);
    axi(1'b1, OFF_CTL, 32'h0);
    br(8'h0a, 1'b1, 2'h0, 0);
    chk("sign only", pred_taken, 1'b1);
    axi(1'b1, OFF_CTL, 32'h3);
    br(8'h0c, 1'b1, 2'h0, 0);
    chk("disabled", pred_taken, 1'b0);
    axi(1'b1, OFF_CTL, 32'h1);
    icache_fill <= 1'b1;
    icache_fill_index <= 8'h0a;
    @(posedge aclk);
    icache_fill <= 1'b0;
    br(8'h0a, 1'b1, 2'h0, 0);
    chk("refilled", pred_taken, 1'b1);
    // five pushes: the oldest falls out of the four entries
    for (i = 0; i < 5; i++) br(i[7:0], 1'b0, HINT_PUSH, 'h100 + i);
    for (i = 4; i > 0; i--) begin
      br(8'h20, 1'b0, HINT_POP, 0);
      chk("pop", {rs_target_valid, rs_target[41:0]}, {1'b1, 42'(32'h100 + i)});
    end
    br(8'h21, 1'b0, HINT_PUSH, 'h200);
    br(8'h22, 1'b0, HINT_COROUT, 'h300);
    chk("coroutine", rs_target, 43'h200);
    br(8'h23, 1'b0, HINT_POP, 0);
    chk("after swap", rs_target, 43'h300);
    $display("branch test done");
  endtask
  task automatic look(input logic [42:0] v, input logic [1:0] m, input logic h,
      input logic [20:0] p);
    virtual_program_counter <= v;
    cur_mode <= m;
    @(posedge aclk);
    @(posedge aclk);
    chk("hit", itb_hit, h);
    if (h) chk("frame", itb_pfn, p);
  endtask
  task automatic t_itb();
    int i;
    // firmware mode keeps lookups from moving the pointers while loading
    firmware_mode <= 1'b1;
    for (i = 0; i < 8; i++) begin
      axi(1'b1, OFF_TAG, i + 1);
      axi(1'b1, OFF_ENTRY, ((i % 2) << ENT_ASM) | (32'h100 + i));
    end
    axi(1'b0, OFF_ENTRY, 32'h0);
    axi(1'b0, OFF_TEMP, 32'h0);
    chk("temp 0", q[21:0], 22'h000100);
    axi(1'b0, OFF_ENTRY, 32'h0);
    axi(1'b0, OFF_TEMP, 32'h0);
    chk("temp 1", q[21:0], 22'h200101);
    firmware_mode <= 1'b0;
    look({30'h3, 13'h0}, MODE_KERNEL, 1'b1, 21'h102);
    axi(1'b1, OFF_SPINV, 32'h0);
    look({30'h3, 13'h0}, MODE_KERNEL, 1'b0, 21'h0);
    look({30'h4, 13'h0}, MODE_KERNEL, 1'b1, 21'h103);
    axi(1'b1, OFF_TSEL, 32'h1);
    axi(1'b1, OFF_TAG, 32'h200);
    axi(1'b1, OFF_ENTRY, 32'h02601400);
    look({30'h205, 13'h0}, MODE_KERNEL, 1'b1, 21'h1405);
    chk("prot", itb_prot, 4'h9);
    axi(1'b1, OFF_CTL, 32'h5);
    look(43'h400_2468_a000, MODE_KERNEL, 1'b1, 21'h12345);
    chk("space match", itb_asm, 1'b1);
    look(43'h400_2468_a000, 2'h3, 1'b0, 21'h0);
    axi(1'b1, OFF_CTL, 32'h1);
    axi(1'b1, OFF_TSEL, 32'h0);
    cur_mode <= MODE_KERNEL;
    $display("translation test done");
  endtask
  // counts deliveries; the pipeline answers each with firmware mode
  task automatic irqs(input int n, output int k);
    int j;
    k = 0;
    for (j = 0; j < n; j++) begin
      @(posedge aclk);
      if (irq_take) begin
        k++;
        firmware_mode <= 1'b1;
      end
    end
  endtask
  task automatic t_irq();
    int k;
    restart_pc <= 43'h123_4567_89ab;
    hw_irq_pin <= 6'h04;
    irqs(8, k);
    chk("masked", k, 0);
    rd(OFF_HREQ, 32'h08, "hw request");
    pipe_drained <= 1'b0;
    axi(1'b1, OFF_HEN, 32'h08);
    irqs(8, k);
    chk("not drained", k, 0);
    pipe_drained <= 1'b1;
    dfill_pending <= 1'b1;
    irqs(8, k);
    chk("fill pending", k, 0);
    dfill_pending <= 1'b0;
    irqs(8, k);
    chk("hw taken", k > 0, 1'b1);
    rd(OFF_RA_LO, 32'h456789ab, "restart address");
    irqs(8, k);
    chk("firmware", k, 0);
    hw_irq_pin <= 6'h00;
    irqs(4, k);
    rd(OFF_HREQ, 32'h0, "withdrawn");
    axi(1'b1, OFF_HEN, 32'h0);
    axi(1'b1, OFF_SEN, 32'h4);
    axi(1'b1, OFF_TEN, 32'h2);
    axi(1'b1, OFF_TREQ, 32'h2);
    firmware_mode <= 1'b0;
    irqs(8, k);
    chk("trap blocked", k, 0);
    cur_mode <= 2'h1;
    irqs(8, k);
    chk("trap taken", k > 0, 1'b1);
    axi(1'b1, OFF_TREQ, 32'h0);
    axi(1'b1, OFF_SREQ, 32'h20);
    axi(1'b1, OFF_SEN, 32'h20);
    firmware_mode <= 1'b0;
    irqs(8, k);
    chk("soft taken", k > 0, 1'b1);
    $display("interrupt test done");
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_issue();
    t_branch();
    t_itb();
    t_irq();
    summarize();
  end
endmodule
`default_nettype wire
